// ===== prss_consts.vh
`ifndef PRSS_CONSTS_VH
`define PRSS_CONSTS_VH
// Register byte offsets
`define PRSS_CTRL_OFF     8'h00
`define PRSS_CONFIG_OFF   8'h04
`define PRSS_STATE_OFF    8'h08
`define PRSS_PERSIST_OFF  8'h0C
`define PRSS_APPOUT_OFF   8'h10
`define PRSS_FALLBK_OFF   8'h14
`define PRSS_FORCEN_OFF   8'h18
`define PRSS_FORCEV_OFF   8'h1C
`define PRSS_OUTS_OFF     8'h20
// Control command bits (write one to act)
`define PRSS_CMD_DOWNLOAD 0
`define PRSS_CMD_XFER_OK  1
`define PRSS_CMD_INIT     2
`define PRSS_CMD_RUN      3
`define PRSS_CMD_STOP     4
`define PRSS_CMD_SAVE     5
`define PRSS_CMD_RESTORE  6
`define PRSS_CMD_REINIT   7
`define PRSS_CMD_CYC_END  8
`define PRSS_CMD_OUTAGE   9
// Configuration field positions
`define PRSS_CFG_MODE_LO  0
`define PRSS_CFG_MODE_HI  1
`define PRSS_CFG_RSIN_EN  2
`define PRSS_CFG_MAINT_LO 8
`define PRSS_CFG_MAINT_HI 15
`define PRSS_CFG_RESET    32'h0000_0001
// Starting modes
`define PRSS_START_RUN    2'h0
`define PRSS_START_STOP   2'h1
`define PRSS_START_PREV   2'h2
// Operating states
`define PRSS_ST_BOOTING   3'h0
`define PRSS_ST_EMPTY     3'h1
`define PRSS_ST_STOPPED   3'h2
`define PRSS_ST_RUNNING   3'h3
`define PRSS_ST_HALTED    3'h4
`define PRSS_ST_POWERLESS 3'h5
// Persistent memory
`define PRSS_AUTO_WORDS   50
`define PRSS_USER_FIRST   50
`define PRSS_USER_MAX     1000
`define PRSS_LOAD_LIMIT   80
// Flash erase time
`define PRSS_ERASE_MS     40
`define PRSS_CLK_KHZ      50000
`define PRSS_ERASE_CYC    (`PRSS_ERASE_MS * `PRSS_CLK_KHZ)
`endif

// ===== prss_sequencer.v
/*
 Operating-state sequencer of a logic controller: state machine, cold and
 warm start, persistent word save/restore and output selection.
 Assumes an AHB-Lite master, synchronous pins, and a host CPU that runs the
 main cycle and pulses cycle-end through the control register.
*/
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
// Functional notes
// - Download erases application, cold start, STOPPED
// - Pending card transfer loads at reboot
// - Initialize: EMPTY, cold start, then STOPPED
// - Switch or enabled input rise requests RUNNING
// - Switch or input low forces STOPPED; code leaves HALTED only on the stop or initialize command
// - Start-up state follows configured starting mode; code always sees the stop mode at boot, as reset loads cfg_r with it
// - Watchdog or load over 80% halts
// - Four causes trigger a cold start
// - Cold start resets blocks, memory, system words
// - Warm start resumes last state unchanged; code warm-starts into STOPPED, as reset loads cfg_r with the stop mode
// - Words 0-49 saved on outage, restored
// - Auto words reset on download, init, reinit
// - User save/restore words 50 to 1049
// - Save request erases flash about 40 ms
// - Staged flash write, then save-done bit
// - Restore completes at end of main cycle
// - Boot, empty, powerless: outputs zero, relays open
// - Stopped, halted: fallback; maintained pulse outputs zero
// - Running: application drives outputs
// - Forcing overrides, tool connected, not pulse outputs
// - Forcing cleared only by cold start, download
// - State word reports operating state
// - Alarm output high only while running
`timescale 1ns/10ps
`include "prss_consts.vh"
module prss_sequencer #(
   parameter NOUT = 8,
   parameter MEMW = 1050,
   parameter ERASE_CYC = `PRSS_ERASE_CYC
) (
   // AHB-Lite slave
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Run/stop and supervision
   input wire run_switch,
   input wire run_input,
   input wire watchdog_expired,
   input wire [6:0] load_percent,
   input wire battery_ok,
   input wire online_mod_valid,
   input wire usb_only_power,
   input wire card_xfer_pending,
   input wire card_xfer_ok,
   input wire tool_connected,
   // Field outputs and status
   output reg [NOUT-1:0] field_out,
   output reg alarm_out,
   output reg cold_start_pulse,
   output reg [2:0] operating_state_word,
   output wire save_done_bit,
   output wire busy
);
   localparam ES_IDLE = 2'h0;
   localparam ES_ERASE = 2'h1;
   localparam ES_WRITE = 2'h2;
   localparam ES_WAIT = 2'h3;

   reg [31:0] memory_word [0:MEMW-1];
   reg [31:0] flash_word [0:MEMW-1];
   reg [2:0] state_r, state_nxt;
   reg [2:0] last_state_r;
   reg [31:0] cfg_r;
   reg [15:0] persist_word_count_r;
   reg [NOUT-1:0] app_out_r, fallback_r, force_en_r, force_val_r;
   reg [7:0] pulse_mask_r;
   reg sw_q_r, in_q_r;
   reg booted_r;
   reg [1:0] es_r;
   reg [31:0] erase_cnt_r;
   reg [10:0] wr_idx_r;
   reg save_request_bit, save_done_r, restore_request_bit;
   reg [7:0] wr_addr_r;
   reg wr_pend_r, rd_pend_r;
   reg [9:0] cmd;
   reg cold, reinit_system_bit, init_go;
   // Initialize takes two steps so the state word shows EMPTY before the cold start
   reg init_pend_r;
   integer i;

   function in_rng;
      input [31:0] idx;
      input [15:0] cnt;
      begin
         in_rng = (idx >= `PRSS_USER_FIRST) && (idx < `PRSS_USER_FIRST + cnt);
      end
   endfunction

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign save_done_bit = save_done_r;
   assign busy = (es_r != ES_IDLE);

   // Address phase capture; data phase in the next cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         rd_pend_r <= hsel && htrans[1] && !hwrite;
         wr_addr_r <= haddr[7:0];
      end
   end

   wire wr_ctrl = wr_pend_r && (wr_addr_r == `PRSS_CTRL_OFF);
   wire rise_run = (run_switch && !sw_q_r) ||
                   (cfg_r[`PRSS_CFG_RSIN_EN] && run_input && !in_q_r);
   wire low_stop = !run_switch || (cfg_r[`PRSS_CFG_RSIN_EN] && !run_input);
   wire fault = watchdog_expired || (load_percent > `PRSS_LOAD_LIMIT);
   wire [1:0] smode = cfg_r[`PRSS_CFG_MODE_HI:`PRSS_CFG_MODE_LO];

   always @* begin
      cmd = wr_ctrl ? hwdata[9:0] : 10'h000;
      cold = 1'b0;
      init_go = 1'b0;
      reinit_system_bit = cmd[`PRSS_CMD_REINIT];
      state_nxt = state_r;
      case (state_r)
         `PRSS_ST_BOOTING: begin
            if (usb_only_power) begin
               // Bus power alone: no transitions until main power reboots us
               state_nxt = `PRSS_ST_POWERLESS;
            end else if (card_xfer_pending) begin
               if (card_xfer_ok) begin
                  state_nxt = `PRSS_ST_STOPPED;
                  cold = 1'b1;
               end else begin
                  state_nxt = `PRSS_ST_EMPTY;
               end
            end else begin
               cold = !online_mod_valid || !battery_ok;
               // Warm start keeps everything, only the state is chosen
               case (smode)
                  `PRSS_START_RUN: state_nxt = `PRSS_ST_RUNNING;
                  `PRSS_START_STOP: state_nxt = `PRSS_ST_STOPPED;
                  default: state_nxt = last_state_r;
               endcase
               if (low_stop && state_nxt == `PRSS_ST_RUNNING) begin
                  state_nxt = `PRSS_ST_STOPPED;
               end
            end
         end
         `PRSS_ST_POWERLESS: state_nxt = `PRSS_ST_POWERLESS;
         `PRSS_ST_EMPTY: begin
            if (cmd[`PRSS_CMD_XFER_OK]) begin
               state_nxt = `PRSS_ST_STOPPED;
               cold = 1'b1;
            end else if (init_pend_r) begin
               // Second half of initialize: cold start out of EMPTY
               state_nxt = `PRSS_ST_STOPPED;
               cold = 1'b1;
            end
         end
         default: begin
            if (state_r == `PRSS_ST_RUNNING && fault) begin
               state_nxt = `PRSS_ST_HALTED;
            end else if (state_r == `PRSS_ST_HALTED) begin
               if (cmd[`PRSS_CMD_STOP]) begin
                  state_nxt = `PRSS_ST_STOPPED;
               end
            end else if (low_stop || cmd[`PRSS_CMD_STOP]) begin
               state_nxt = `PRSS_ST_STOPPED;
            end else if (rise_run || cmd[`PRSS_CMD_RUN]) begin
               state_nxt = `PRSS_ST_RUNNING;
            end
         end
      endcase
      // Download enters EMPTY only from STOPPED; tool must stop first
      if (cmd[`PRSS_CMD_DOWNLOAD] && state_r == `PRSS_ST_STOPPED) begin
         state_nxt = `PRSS_ST_EMPTY;
      end
      // Initialize first drops to EMPTY; the cold start follows on the next cycle
      if (cmd[`PRSS_CMD_INIT] && state_r != `PRSS_ST_BOOTING && state_r != `PRSS_ST_POWERLESS) begin
         state_nxt = `PRSS_ST_EMPTY;
         init_go = 1'b1;
      end
      // Flash erase occupies the controller; no transitions meanwhile
      if (es_r == ES_ERASE && state_r != `PRSS_ST_BOOTING) begin
         state_nxt = state_r;
         cold = 1'b0;
         init_go = 1'b0;
      end
   end

   wire auto_clr = cmd[`PRSS_CMD_DOWNLOAD] || cmd[`PRSS_CMD_INIT] || reinit_system_bit;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= `PRSS_ST_BOOTING;
         last_state_r <= `PRSS_ST_STOPPED;
         cfg_r <= `PRSS_CFG_RESET;
         persist_word_count_r <= 16'h0000;
         app_out_r <= {NOUT{1'b0}};
         fallback_r <= {NOUT{1'b0}};
         force_en_r <= {NOUT{1'b0}};
         force_val_r <= {NOUT{1'b0}};
         pulse_mask_r <= 8'h00;
         sw_q_r <= 1'b0;
         in_q_r <= 1'b0;
         booted_r <= 1'b0;
         init_pend_r <= 1'b0;
         cold_start_pulse <= 1'b0;
         es_r <= ES_IDLE;
         erase_cnt_r <= 32'h0000_0000;
         wr_idx_r <= 11'h000;
         save_request_bit <= 1'b0;
         save_done_r <= 1'b0;
         restore_request_bit <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // Kept while an erase freezes EMPTY, so the cold start still follows
         init_pend_r <= init_go || (init_pend_r && state_nxt == `PRSS_ST_EMPTY);
         // Boot consumes the first edge, so the reset value cannot fake a rise
         sw_q_r <= run_switch;
         in_q_r <= run_input;
         booted_r <= 1'b1;
         cold_start_pulse <= cold;
         if (state_nxt != `PRSS_ST_BOOTING && state_nxt != `PRSS_ST_POWERLESS) begin
            last_state_r <= state_nxt;
         end
         if (!booted_r) begin
            // Words 0-49 come back from flash every boot
            for (i = 0; i < `PRSS_AUTO_WORDS; i = i + 1) begin
               memory_word[i] <= flash_word[i];
            end
         end
         if (cmd[`PRSS_CMD_OUTAGE]) begin
            for (i = 0; i < `PRSS_AUTO_WORDS; i = i + 1) begin
               flash_word[i] <= memory_word[i];
            end
         end
         if (cold) begin
            // Memory above the auto words cleared; app_out reset
            for (i = `PRSS_AUTO_WORDS; i < MEMW; i = i + 1) begin
               memory_word[i] <= 32'h0000_0000;
            end
            app_out_r <= {NOUT{1'b0}};
            force_en_r <= {NOUT{1'b0}};
         end
         if (auto_clr) begin
            for (i = 0; i < `PRSS_AUTO_WORDS; i = i + 1) begin
               memory_word[i] <= 32'h0000_0000;
               flash_word[i] <= 32'h0000_0000;
            end
         end
         if (cmd[`PRSS_CMD_DOWNLOAD]) begin
            force_en_r <= {NOUT{1'b0}};
         end
         if (wr_pend_r) begin
            case (wr_addr_r)
               `PRSS_CONFIG_OFF: cfg_r <= hwdata;
               `PRSS_PERSIST_OFF: persist_word_count_r <= (hwdata[15:0] > `PRSS_USER_MAX) ?
                                  16'd`PRSS_USER_MAX : hwdata[15:0];
               `PRSS_APPOUT_OFF: app_out_r <= hwdata[NOUT-1:0];
               `PRSS_FALLBK_OFF: fallback_r <= hwdata[NOUT-1:0];
               `PRSS_FORCEN_OFF: if (tool_connected) force_en_r <= hwdata[NOUT-1:0];
               `PRSS_FORCEV_OFF: if (tool_connected) force_val_r <= hwdata[NOUT-1:0];
               default: ;
            endcase
         end
         pulse_mask_r <= cfg_r[`PRSS_CFG_MAINT_HI:`PRSS_CFG_MAINT_LO];
         if (cmd[`PRSS_CMD_SAVE]) begin
            save_request_bit <= 1'b1;
            save_done_r <= 1'b0;
         end
         if (cmd[`PRSS_CMD_RESTORE]) begin
            restore_request_bit <= 1'b1;
         end
         if (restore_request_bit && cmd[`PRSS_CMD_CYC_END] && es_r == ES_IDLE) begin
            for (i = 0; i < MEMW; i = i + 1) begin
               if (in_rng(i, persist_word_count_r)) memory_word[i] <= flash_word[i];
            end
            restore_request_bit <= cmd[`PRSS_CMD_RESTORE];
         end
         case (es_r)
            ES_IDLE: begin
               if (save_request_bit && cmd[`PRSS_CMD_CYC_END]) begin
                  es_r <= ES_ERASE;
                  erase_cnt_r <= ERASE_CYC - 1;
                  save_request_bit <= cmd[`PRSS_CMD_SAVE];
               end
            end
            ES_ERASE: begin
               if (erase_cnt_r == 32'h0000_0000) begin
                  es_r <= ES_WAIT;
                  wr_idx_r <= 11'd`PRSS_USER_FIRST;
                  for (i = `PRSS_USER_FIRST; i < MEMW; i = i + 1) begin
                     flash_word[i] <= 32'hFFFF_FFFF;
                  end
               end else begin
                  erase_cnt_r <= erase_cnt_r - 32'h0000_0001;
               end
            end
            ES_WAIT: begin
               // One word written per main-cycle gap
               if (cmd[`PRSS_CMD_CYC_END]) es_r <= ES_WRITE;
            end
            default: begin
               if (in_rng({21'h0, wr_idx_r}, persist_word_count_r)) begin
                  flash_word[wr_idx_r] <= memory_word[wr_idx_r];
                  wr_idx_r <= wr_idx_r + 11'h001;
                  es_r <= ES_WAIT;
               end else begin
                  es_r <= ES_IDLE;
                  save_done_r <= 1'b1;
               end
            end
         endcase
      end
   end

   // Output selection per state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         field_out <= {NOUT{1'b0}};
         alarm_out <= 1'b0;
         operating_state_word <= `PRSS_ST_BOOTING;
      end else begin
         operating_state_word <= state_r;
         alarm_out <= (state_r == `PRSS_ST_RUNNING);
         for (i = 0; i < NOUT; i = i + 1) begin
            case (state_r)
               `PRSS_ST_RUNNING: field_out[i] <= app_out_r[i];
               `PRSS_ST_STOPPED, `PRSS_ST_HALTED:
                  field_out[i] <= (i < 8 && pulse_mask_r[i % 8]) ? 1'b0 : fallback_r[i];
               default: field_out[i] <= 1'b0;
            endcase
            // Pulse/counter channels cannot be forced
            if (force_en_r[i] && !(i < 8 && pulse_mask_r[i % 8]) &&
                state_r != `PRSS_ST_BOOTING && state_r != `PRSS_ST_EMPTY && state_r != `PRSS_ST_POWERLESS) begin
               field_out[i] <= force_val_r[i];
            end
         end
      end
   end

   // Read data for the data phase
   always @* begin
      hrdata = 32'h0000_0000;
      if (rd_pend_r) begin
         case (wr_addr_r)
            `PRSS_CONFIG_OFF: hrdata = cfg_r;
            `PRSS_STATE_OFF: hrdata = {26'h0, busy, save_done_r, 1'b0, state_r};
            `PRSS_PERSIST_OFF: hrdata = {16'h0, persist_word_count_r};
            `PRSS_APPOUT_OFF: hrdata = {{(32-NOUT){1'b0}}, app_out_r};
            `PRSS_FALLBK_OFF: hrdata = {{(32-NOUT){1'b0}}, fallback_r};
            `PRSS_FORCEN_OFF: hrdata = {{(32-NOUT){1'b0}}, force_en_r};
            `PRSS_FORCEV_OFF: hrdata = {{(32-NOUT){1'b0}}, force_val_r};
            `PRSS_OUTS_OFF: hrdata = {{(32-NOUT){1'b0}}, field_out};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end
endmodule

// ===== prss_sequencer_properties.sv
/*
 Concurrent checks on the run-state sequencer ports.
 Assumes binding into prss_sequencer, one clock, hresetn async active low.
*/
`timescale 1ns/10ps
`include "prss_consts.vh"
module prss_seq_props #(
   parameter NOUT = 8,
   parameter ERASE_CYC = 10
) (
   // Clock, reset and bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   // Supervision
   input wire run_switch,
   input wire watchdog_expired,
   input wire [6:0] load_percent,
   // Outputs
   input wire [NOUT-1:0] field_out,
   input wire alarm_out,
   input wire cold_start_pulse,
   input wire [2:0] operating_state_word,
   input wire busy
);
   reg [1:0] ctrl_age_r;
   reg [31:0] busy_len_r;
   wire ctrl_wr = hsel && htrans[1] && hwrite && haddr[7:0] == `PRSS_CTRL_OFF;
   // Age of the last control write, so a halt exit can be traced to a command
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_age_r <= 2'h0;
         busy_len_r <= 32'h0;
      end else begin
         ctrl_age_r <= ctrl_wr ? 2'h3 : (ctrl_age_r != 2'h0 ? ctrl_age_r - 2'h1 : 2'h0);
         busy_len_r <= busy ? busy_len_r + 32'h1 : 32'h0;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_run;
      operating_state_word == `PRSS_ST_RUNNING;
   endsequence
   sequence s_halt;
      operating_state_word == `PRSS_ST_HALTED;
   endsequence
   sequence s_halt_exit;
      s_halt ##1 operating_state_word != `PRSS_ST_HALTED;
   endsequence
   wire run_q = operating_state_word == `PRSS_ST_RUNNING && run_switch && !busy;
   wire in_run = operating_state_word == `PRSS_ST_RUNNING;
   alarm_run_a: assert property (s_run ##1 s_run |-> alarm_out)
      else $error("Alarm low while running");
   alarm_off_a: assert property (alarm_out |-> operating_state_word == `PRSS_ST_RUNNING ||
      $past(operating_state_word) == `PRSS_ST_RUNNING) else $error("Alarm high outside running");
   init_zero_a: assert property ((operating_state_word == `PRSS_ST_EMPTY ||
      operating_state_word == `PRSS_ST_POWERLESS) && $stable(operating_state_word) |-> field_out == 0)
      else $error("Outputs not at initialization values");
   wd_halt_a: assert property (run_q && watchdog_expired |-> ##[1:3] s_halt)
      else $error("Watchdog did not halt");
   load_halt_a: assert property (run_q && load_percent > 7'd80 |-> ##[1:3] s_halt)
      else $error("Overload did not halt");
   halt_keep_a: assert property (s_halt_exit |-> ctrl_age_r != 2'h0 || !$past(run_switch))
      else $error("Halt left without a command");
   sw_stop_a: assert property (!run_switch && in_run && !busy |-> ##[1:3]
      operating_state_word == `PRSS_ST_STOPPED) else $error("Switch low did not stop");
   rise_run_a: assert property ($rose(run_switch) && operating_state_word == `PRSS_ST_STOPPED &&
      !busy && !watchdog_expired && load_percent <= 7'd80 |-> ##[1:3] s_run)
      else $error("Switch rise did not run");
   cold_pulse_a: assert property (cold_start_pulse |=> !cold_start_pulse)
      else $error("Cold start pulse too long");
   erase_len_a: assert property ($fell(busy) |-> busy_len_r >= ERASE_CYC)
      else $error("Flash busy shorter than erase");
endmodule
bind prss_sequencer prss_seq_props #(.NOUT(NOUT), .ERASE_CYC(ERASE_CYC)) u_props (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .run_switch(run_switch), .watchdog_expired(watchdog_expired), .load_percent(load_percent),
   .field_out(field_out), .alarm_out(alarm_out), .cold_start_pulse(cold_start_pulse),
   .operating_state_word(operating_state_word), .busy(busy));

// ===== prss_field_side.sv
/*
 Far-side model: front run/stop switch and configured run/stop input.
 Assumes the bench requests levels; pins move only on a clock edge.
*/
`timescale 1ns/10ps
module prss_field_side (
   // Clock
   input wire hclk,
   // Requests from the bench
   input wire sw_cmd,
   input wire in_cmd,
   // Pins toward the sequencer
   output reg run_switch,
   output reg run_input
);
   // Contacts settle on a clock edge, so the sequencer never sees a mid-cycle glitch
   always @(posedge hclk) begin
      run_switch <= sw_cmd;
      run_input <= in_cmd;
   end
endmodule

// ===== tb_plc_run_state_sequencer.sv
/*
 Self-checking bench for the run-state sequencer.
 Assumes zero-wait AHB-Lite slave and a shortened erase count.
*/
`timescale 1ns/10ps
`include "prss_consts.vh"
module tb_plc_run_state_sequencer;
   localparam [2:0] STP = `PRSS_ST_STOPPED;
   localparam [2:0] RUN = `PRSS_ST_RUNNING;
   localparam [2:0] HLT = `PRSS_ST_HALTED;
   reg hclk, hresetn, hsel, hwrite, wd, tool, sw_cmd, in_cmd, bat, usb, cpend, cok, omv;
   reg [31:0] haddr, hwdata, rdv;
   reg [1:0] htrans;
   reg [6:0] load;
   reg [7:0] app, fb, fv;
   wire hreadyout, hresp, alarm_out, cold, save_done_bit, busy, run_switch, run_input;
   wire [31:0] hrdata;
   wire [7:0] field_out;
   wire [2:0] st;
   integer fail_count = 0;
   integer num_checks = 0;
   integer i, n;
   prss_sequencer #(.NOUT(8), .MEMW(1050), .ERASE_CYC(10)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run_switch(run_switch),
      .run_input(run_input), .watchdog_expired(wd), .load_percent(load), .battery_ok(bat),
      .online_mod_valid(omv), .usb_only_power(usb), .card_xfer_pending(cpend), .card_xfer_ok(cok),
      .tool_connected(tool), .field_out(field_out), .alarm_out(alarm_out), .cold_start_pulse(cold),
      .operating_state_word(st), .save_done_bit(save_done_bit), .busy(busy));
   prss_field_side u_field (.hclk(hclk), .sw_cmd(sw_cmd), .in_cmd(in_cmd), .run_switch(run_switch),
      .run_input(run_input));
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task w(input integer c);
      repeat (c) @(posedge hclk);
   endtask
   task bus(input wr, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= wr;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         rdv = hrdata;
      end
   endtask
   task cmd(input integer b);
      bus(1'b1, `PRSS_CTRL_OFF, 32'h1 << b);
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Pulse channel 7 is masked: zero when stopped and never forced
   function [7:0] eo(input [2:0] s, input [7:0] fe);
      reg [7:0] b;
      begin
         b = s == RUN ? app : (s == STP || s == HLT) ? fb & 8'h7F : 8'h00;
         eo = (b & ~(fe & 8'h7F)) | (fv & fe & 8'h7F);
      end
   endfunction
   task summarize;
      begin
         $display("checks %0d errors %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (5000) @(posedge hclk);
      fail_count = fail_count + 1;
      summarize;
   end
   initial begin
      {hresetn, hsel, hwrite, wd, tool, usb, cpend, cok, omv} = 9'h000;
      {sw_cmd, in_cmd, bat} = 3'h7;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      load = 7'h00;
      rdv = $urandom(46);
      app = $urandom;
      fb = $urandom;
      fv = $urandom;
      w(8);
      hresetn <= 1'b1;
      w(3);
      chk(st, STP);
      bus(1'b0, `PRSS_CONFIG_OFF, 32'h0);
      chk(rdv, `PRSS_CFG_RESET);
      bus(1'b0, `PRSS_STATE_OFF, 32'h0);
      chk(rdv[2:0], STP);
      chk(hresp, 1'b0);
      bus(1'b0, 32'h40, 32'h0);
      chk(rdv, 32'h0);
      bus(1'b1, `PRSS_CONFIG_OFF, 32'h8005);
      bus(1'b1, `PRSS_APPOUT_OFF, {24'h0, app});
      bus(1'b1, `PRSS_FALLBK_OFF, {24'h0, fb});
      w(2);
      chk(field_out, eo(STP, 8'h00));
      cmd(`PRSS_CMD_RUN);
      load <= 7'd80;
      w(3);
      chk(st, RUN);
      chk(alarm_out, 1'b1);
      chk(field_out, eo(RUN, 8'h00));
      for (i = 0; i < 2; i = i + 1) begin
         if (i == 0)
            sw_cmd <= 1'b0;
         else
            in_cmd <= 1'b0;
         w(4);
         chk(st, STP);
         chk(alarm_out, 1'b0);
         sw_cmd <= 1'b1;
         in_cmd <= 1'b1;
         w(4);
         chk(st, RUN);
      end
      for (i = 0; i < 2; i = i + 1) begin
         if (i == 0)
            wd <= 1'b1;
         else
            load <= 7'd81;
         w(3);
         chk(st, HLT);
         chk(field_out, eo(HLT, 8'h00));
         wd <= 1'b0;
         load <= 7'h00;
         cmd(`PRSS_CMD_RUN);
         w(2);
         chk(st, HLT);
         cmd(`PRSS_CMD_STOP);
         cmd(`PRSS_CMD_RUN);
         w(2);
         chk(st, RUN);
      end
      for (i = 0; i < 2; i = i + 1) begin
         tool <= i == 1;
         w(1);
         bus(1'b1, `PRSS_FORCEN_OFF, 32'hFF);
         bus(1'b1, `PRSS_FORCEV_OFF, {24'h0, fv});
         w(2);
         chk(field_out, eo(RUN, i == 1 ? 8'hFF : 8'h00));
      end
      tool <= 1'b0;
      w(2);
      chk(field_out, eo(RUN, 8'hFF));
      cmd(`PRSS_CMD_STOP);
      w(2);
      chk(field_out, eo(STP, 8'hFF));
      cmd(`PRSS_CMD_DOWNLOAD);
      w(2);
      chk(st, `PRSS_ST_EMPTY);
      chk(field_out, 8'h00);
      cmd(`PRSS_CMD_XFER_OK);
      w(2);
      chk(st, STP);
      bus(1'b1, `PRSS_CONFIG_OFF, 32'h8005);
      bus(1'b1, `PRSS_FALLBK_OFF, {24'h0, fb});
      w(2);
      chk(field_out, eo(STP, 8'h00));
      cmd(`PRSS_CMD_INIT);
      w(2);
      chk(st, `PRSS_ST_EMPTY);
      n = 0;
      while (cold !== 1'b1 && n < 20) begin
         w(1);
         n = n + 1;
      end
      chk(n < 20, 1'b1);
      w(3);
      chk(st, STP);
      bus(1'b1, `PRSS_PERSIST_OFF, 32'd2000);
      bus(1'b0, `PRSS_PERSIST_OFF, 32'h0);
      chk(rdv, 32'd1000);
      bus(1'b1, `PRSS_PERSIST_OFF, 32'd3);
      cmd(`PRSS_CMD_SAVE);
      cmd(`PRSS_CMD_CYC_END);
      w(2);
      chk(busy, 1'b1);
      w(12);
      n = 0;
      while (save_done_bit !== 1'b1 && n < 10) begin
         cmd(`PRSS_CMD_CYC_END);
         w(1);
         n = n + 1;
      end
      chk(save_done_bit, 1'b1);
      cmd(`PRSS_CMD_RESTORE);
      cmd(`PRSS_CMD_CYC_END);
      w(2);
      chk(busy, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         hresetn <= 1'b0;
         usb <= i == 1;
         cpend <= i == 0 || i == 2;
         cok <= i == 2;
         omv <= i == 3;
         w(2);
         hresetn <= 1'b1;
         w(2);
         chk(cold, i == 2);
         w(1);
         chk(st, i == 1 ? `PRSS_ST_POWERLESS : i == 0 ? `PRSS_ST_EMPTY : STP);
         chk(field_out, 8'h00);
      end
      summarize;
   end
endmodule
